// File: gim_map.svh
/*
 Timing counts, field positions and reset values for the init and mode block.
 Assumes a 100 MHz system clock; included by its bare name.
*/
`ifndef GIM_MAP_SVH
`define GIM_MAP_SVH
`define GIM_CLK_PERIOD_NS   10
`define GIM_FAST_SETTLE_NS  500
`define GIM_SLOW_SETTLE_NS  2000
`define GIM_IFC_HOLD_US     100
`define GIM_FAST_SETTLE_CYC ((`GIM_FAST_SETTLE_NS + `GIM_CLK_PERIOD_NS - 1) / `GIM_CLK_PERIOD_NS)
`define GIM_SLOW_SETTLE_CYC ((`GIM_SLOW_SETTLE_NS + `GIM_CLK_PERIOD_NS - 1) / `GIM_CLK_PERIOD_NS)
`define GIM_IFC_HOLD_CYC    ((`GIM_IFC_HOLD_US * 1000 + `GIM_CLK_PERIOD_NS - 1) / `GIM_CLK_PERIOD_NS)
`define GIM_MODE_SPEED_BIT  2
`define GIM_MODE_ROLE_BIT   1
`define GIM_ADDR_MAX        5'h1E
`define GIM_ADDR_RST        5'h00
`define GIM_MODE_RST        8'h02
`endif

// File: gim_pkg.sv
/*
 Types for the init and mode block.
 Assumes gim_map.svh provides the numeric constants.
*/
`default_nettype none
package gim_pkg;
   typedef enum logic [1:0] {GIM_IDLE, GIM_IFC_HOLD} gim_state_e;
   // Wide enough for the full default hold count of a clear pulse
   typedef logic [13:0] gim_cnt_t;
endpackage
`default_nettype wire

// File: gim_init_mode.sv
/*
 Init and mode selection for a bus interface: takes own address and mode
 byte, picks settle time and role, and pulses interface-clear as controller.
 The settle count is only exported; a handshake engine elsewhere uses it.
 Assumes INIT_STB_I is a one-cycle pulse from same-clock host logic, so no
 synchroniser stands on the request inputs, and that an external pull-up
 holds the interface-clear wire high while the enable is high.
*/
// Contract
// - Own address 0 to 30 is accepted and used as the bus address.
// - Speed bit 1 selects fast handshake with about 500 ns settling.
// - Speed bit 0 selects slow handshake with about 2 us settling.
// - Role bit 1 makes the block a plain device, 0 the system controller.
// - Choosing controller at init asserts interface-clear briefly then releases it.
// - Speed bit sits at position 2 and role bit at position 1, so mode 4 is fast controller.
`timescale 1ns/10ps
`default_nettype none
`include "gim_map.svh"
module gim_init_mode
   import gim_pkg::*;
#(
   parameter int IFC_HOLD_CYC = `GIM_IFC_HOLD_CYC
) (
   input  wire logic       CLK_SYS_I,
   input  wire logic       RST_B_I,
   input  wire logic       INIT_STB_I,
   input  wire logic [4:0] INIT_ADDR_I,
   input  wire logic [7:0] INIT_MODE_I,
   output logic            INIT_ERR_O,
   output logic [4:0]      OWN_ADDR_O,
   output logic            FAST_HS_O,
   output logic [7:0]      SETTLE_CYC_O,
   output logic            DEVICE_ROLE_SELECT_O,
   output logic            SYS_CTRL_O,
   output logic            IFC_O,
   output logic            IFC_OE_B_O,
   output logic            BUSY_O
);
   // Settle counts and the reset mode byte, sized to the ports they feed
   localparam logic [7:0] FAST_CYC = 8'(`GIM_FAST_SETTLE_CYC);
   localparam logic [7:0] SLOW_CYC = 8'(`GIM_SLOW_SETTLE_CYC);
   localparam logic [7:0] MODE_RST = `GIM_MODE_RST;

   gim_state_e state;
   gim_cnt_t   ifc_cnt;
   logic       addr_ok;

   assign addr_ok = (INIT_ADDR_I <= `GIM_ADDR_MAX);

   // Address capture and error flag
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_B_I) begin
         OWN_ADDR_O <= `GIM_ADDR_RST;
         INIT_ERR_O <= 1'b0;
      end else if (INIT_STB_I && state == GIM_IDLE) begin
         INIT_ERR_O <= !addr_ok;
         if (addr_ok) begin
            OWN_ADDR_O <= INIT_ADDR_I;
         end
      end
   end

   // Mode decode: only speed and role bits are kept
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_B_I) begin
         FAST_HS_O            <= MODE_RST[`GIM_MODE_SPEED_BIT];
         SETTLE_CYC_O         <= MODE_RST[`GIM_MODE_SPEED_BIT] ? FAST_CYC : SLOW_CYC;
         DEVICE_ROLE_SELECT_O <= MODE_RST[`GIM_MODE_ROLE_BIT];
         SYS_CTRL_O           <= !MODE_RST[`GIM_MODE_ROLE_BIT];
      end else if (INIT_STB_I && state == GIM_IDLE && addr_ok) begin
         FAST_HS_O            <= INIT_MODE_I[`GIM_MODE_SPEED_BIT];
         SETTLE_CYC_O         <= INIT_MODE_I[`GIM_MODE_SPEED_BIT] ? FAST_CYC
                                                                  : SLOW_CYC;
         DEVICE_ROLE_SELECT_O <= INIT_MODE_I[`GIM_MODE_ROLE_BIT];
         SYS_CTRL_O           <= !INIT_MODE_I[`GIM_MODE_ROLE_BIT];
      end
   end

   // Interface-clear pulse sequencer
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_B_I) begin
         state   <= GIM_IDLE;
         ifc_cnt <= '0;
      end else begin
         unique case (state)
            GIM_IDLE: begin
               if (INIT_STB_I && addr_ok && !INIT_MODE_I[`GIM_MODE_ROLE_BIT]) begin
                  state   <= GIM_IFC_HOLD;
                  ifc_cnt <= gim_cnt_t'(IFC_HOLD_CYC - 1);
               end
            end
            GIM_IFC_HOLD: begin
               if (ifc_cnt == '0) begin
                  state <= GIM_IDLE;
               end else begin
                  ifc_cnt <= ifc_cnt - 1'b1;
               end
            end
            default: state <= GIM_IDLE;
         endcase
      end
   end

   // Open-drain interface-clear: low level driven while enable is low
   assign IFC_O      = 1'b0;
   assign IFC_OE_B_O = (state != GIM_IFC_HOLD);
   assign BUSY_O     = (state == GIM_IFC_HOLD);

   // Length of the running clear pulse in cycles, read only by the checks below
   int unsigned hold_len;
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_B_I || !BUSY_O) begin
         hold_len <= '0;
      end else begin
         hold_len <= hold_len + 32'h0000_0001;
      end
   end

   // Strobe taken while idle with a legal address and the controller role
   sequence ctrl_init_s;
      INIT_STB_I && !BUSY_O && addr_ok && !INIT_MODE_I[`GIM_MODE_ROLE_BIT];
   endsequence

   // Strobe taken while idle with a legal address and the device role
   sequence dev_init_s;
      INIT_STB_I && !BUSY_O && addr_ok && INIT_MODE_I[`GIM_MODE_ROLE_BIT];
   endsequence

   // Strobe taken while idle with a legal address, either role
   sequence take_ok_s;
      INIT_STB_I && !BUSY_O && addr_ok;
   endsequence

   // Strobe taken while idle with the one refused address
   sequence take_bad_s;
      INIT_STB_I && !BUSY_O && !addr_ok;
   endsequence

   // Strobe that arrives while a clear pulse still runs and must be ignored
   sequence take_busy_s;
      INIT_STB_I && BUSY_O;
   endsequence

   // Clear low on the first edge and still low on the next; needs a hold of 2 or more
   sequence ifc_on_s;
      !IFC_OE_B_O && BUSY_O ##1 !IFC_OE_B_O;
   endsequence

   // Final counted cycle of the pulse
   sequence ifc_last_s;
      BUSY_O && ifc_cnt == '0;
   endsequence

   // Line let go and the block ready for a new strobe
   sequence ifc_off_s;
      IFC_OE_B_O && !BUSY_O;
   endsequence

   // Controller init starts the clear pulse on the next edge
   ifc_start_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
      ctrl_init_s |=> ifc_on_s) else $error("interface-clear not asserted");

   // The pulse ends on the edge after the counter runs out
   ifc_release_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
      ifc_last_s |=> ifc_off_s) else $error("interface-clear not released");

   // A finished pulse lasted exactly the hold count
   ifc_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
      $rose(IFC_OE_B_O) |-> hold_len == IFC_HOLD_CYC) else $error("clear hold wrong");

   // A running pulse never outlasts the hold count
   ifc_bound_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
      !IFC_OE_B_O |-> hold_len < IFC_HOLD_CYC) else $error("clear hold too long");

   // Device role never pulls clear and leaves the role outputs as a device
   dev_no_ifc_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
      dev_init_s |=> IFC_OE_B_O && DEVICE_ROLE_SELECT_O && !SYS_CTRL_O)
      else $error("device role pulsed clear");

   // The two role outputs always disagree
   role_pair_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
      SYS_CTRL_O != DEVICE_ROLE_SELECT_O) else $error("role outputs agree");

   // Fast handshake settles in 500 ns, 50 cycles at 100 MHz
   fast_settle_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
      FAST_HS_O |-> SETTLE_CYC_O == 8'h32) else $error("fast settle wrong");

   // Slow handshake settles in 2 us, 200 cycles at 100 MHz
   slow_settle_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
      !FAST_HS_O |-> SETTLE_CYC_O == 8'hC8) else $error("slow settle wrong");

   // Mode value 4 gives a fast system controller
   mode_four_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
      (INIT_STB_I && !BUSY_O && addr_ok && INIT_MODE_I[2:1] == 2'h2)
      |=> FAST_HS_O && SYS_CTRL_O) else $error("mode four misdecoded");

   // Only the speed and role bits of the mode byte reach the outputs
   mode_keep_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
      take_ok_s |=> FAST_HS_O == $past(INIT_MODE_I[`GIM_MODE_SPEED_BIT])
                    && DEVICE_ROLE_SELECT_O == $past(INIT_MODE_I[`GIM_MODE_ROLE_BIT]))
      else $error("mode bits misplaced");

   // A legal address is taken and clears the error flag
   addr_take_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
      take_ok_s |=> OWN_ADDR_O == $past(INIT_ADDR_I) && !INIT_ERR_O)
      else $error("address not taken");

   // A refused address leaves the whole configuration alone
   addr_bad_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
      take_bad_s |=> $stable(OWN_ADDR_O) && $stable(FAST_HS_O)
                     && $stable(DEVICE_ROLE_SELECT_O) && INIT_ERR_O && IFC_OE_B_O)
      else $error("bad address accepted");

   // Strobes during a running pulse change nothing
   busy_ignore_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
      take_busy_s |=> $stable(OWN_ADDR_O) && $stable(FAST_HS_O)
                      && $stable(DEVICE_ROLE_SELECT_O) && $stable(INIT_ERR_O))
      else $error("strobe taken while busy");

   // The stored bus address never leaves the legal range
   addr_range_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
      OWN_ADDR_O <= `GIM_ADDR_MAX) else $error("own address out of range");
endmodule
`default_nettype wire

// File: gim_bus_model.sv
/* Far-side instruments sharing the interface-clear wire.
   Assumes open-drain drive with active-low enable and a pull-up. */
`timescale 1ns/10ps
`default_nettype none
module gim_bus_model (
   input  wire logic IFC_I,
   input  wire logic IFC_OE_B_I,
   output logic      IFC_LINE_O
);
   // Pull-up holds the line high unless the block drives it
   assign IFC_LINE_O = IFC_OE_B_I ? 1'b1 : IFC_I;
endmodule
`default_nettype wire

// File: test_gim_init_mode.sv
/* Testbench for the init and mode block.
   Assumes a 100 MHz clock and a shortened interface-clear hold. */
`timescale 1ns/10ps
`default_nettype none
module test_gim_init_mode;
   localparam int HOLD = 8;
   logic       clk, rst_b, stb, err, fast, role, ctrl, ifc, oe_b, busy, line;
   logic [4:0] addr, own;
   logic [7:0] mode, settle;
   int         bad_count, n_checks, cyc, n;
   gim_init_mode #(.IFC_HOLD_CYC(HOLD)) i_gim_init_mode (.CLK_SYS_I(clk), .RST_B_I(rst_b),
      .INIT_STB_I(stb), .INIT_ADDR_I(addr), .INIT_MODE_I(mode), .INIT_ERR_O(err),
      .OWN_ADDR_O(own), .FAST_HS_O(fast), .SETTLE_CYC_O(settle),
      .DEVICE_ROLE_SELECT_O(role), .SYS_CTRL_O(ctrl), .IFC_O(ifc),
      .IFC_OE_B_O(oe_b), .BUSY_O(busy));
   gim_bus_model i_gim_bus_model (.IFC_I(ifc), .IFC_OE_B_I(oe_b), .IFC_LINE_O(line));
   // Compare one value and count it
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Compare the whole configuration
   task cfg(input logic [4:0] a, input logic f, input logic [7:0] s, input logic r);
      chk("addr", {3'h0, a}, {3'h0, own});
      chk("fast", {7'h00, f}, {7'h00, fast});
      chk("settle", s, settle);
      chk("role", {6'h00, r, ~r}, {6'h00, role, ctrl});
   endtask
   // One-cycle strobe; outputs settle by the next falling edge
   task init(input logic [4:0] a, input logic [7:0] m);
      stb = 1'b1;
      addr = a;
      mode = m;
      @(negedge clk);
      stb = 1'b0;
   endtask
   task t_reset;
      cfg(5'h00, 1'b0, 8'hC8, 1'b1);
      chk("line", 8'h01, {7'h00, line});
      chk("busy", 8'h00, {7'h00, busy});
      chk("err", 8'h00, {7'h00, err});
   endtask
   // Fast controller, a strobe ignored mid-pulse, then the pulse length
   task t_ctrl;
      init(5'h00, 8'h04);
      cfg(5'h00, 1'b1, 8'h32, 1'b0);
      chk("busy", 8'h01, {7'h00, busy});
      n = 0;
      if (line === 1'b0) n++;
      @(negedge clk);
      if (line === 1'b0) n++;
      init(5'h05, 8'h02);
      chk("addr", 8'h00, {3'h0, own});
      cfg(5'h00, 1'b1, 8'h32, 1'b0);
      repeat (20) begin
         if (line === 1'b0) n++;
         @(negedge clk);
      end
      chk("hold", 8'(HOLD), n[7:0]);
      chk("busy", 8'h00, {7'h00, busy});
   endtask
   task t_bad;
      init(5'h1F, 8'hFB);
      chk("err", 8'h01, {7'h00, err});
      cfg(5'h00, 1'b1, 8'h32, 1'b0);
   endtask
   task t_dev;
      @(negedge clk);
      init(5'h1E, 8'hFB);
      chk("err", 8'h00, {7'h00, err});
      cfg(5'h1E, 1'b0, 8'hC8, 1'b1);
      chk("line", 8'h01, {7'h00, line});
   endtask
   // Slow controller, cut short by a reset in mid-pulse
   task t_slow;
      @(negedge clk);
      init(5'h03, 8'h00);
      cfg(5'h03, 1'b0, 8'hC8, 1'b0);
      chk("line", 8'h00, {7'h00, line});
      rst_b = 1'b0;
      repeat (3) @(negedge clk);
      rst_b = 1'b1;
      t_reset();
   endtask
   task test_done;
      $display("checks %0d errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         bad_count++;
         test_done();
      end
   end
   initial begin
      rst_b = 1'b0;
      stb = 1'b0;
      addr = 5'h00;
      mode = 8'h00;
      repeat (3) @(negedge clk);
      rst_b = 1'b1;
      t_reset();
      t_ctrl();
      t_bad();
      t_dev();
      t_slow();
      test_done();
   end
endmodule
`default_nettype wire
